// ---- pkg/msel_pkg.sv ----
// Shared constants and types of the master selector
package msel_pkg;
	// Pointer values of the upstream register set
	localparam logic [1:0] PTR_MASK = 2'h0;
	localparam logic [1:0] PTR_CTRL = 2'h1;
	localparam logic [1:0] PTR_STAT = 2'h2;
	localparam logic [1:0] PTR_NONE = 2'h3;
	// Control register bit positions
	localparam int CTL_SEL   = 0;
	localparam int CTL_PSEL  = 1;
	localparam int CTL_CON   = 2;
	localparam int CTL_PCON  = 3;
	localparam int CTL_RREQ  = 4;
	localparam int CTL_TEST  = 6;
	localparam int CTL_PTEST = 7;
	// Mask and status bit positions (same layout)
	localparam int MSK_INTIN = 0;
	localparam int MSK_RDONE = 1;
	localparam int MSK_DIRTY = 2;
	localparam int MSK_LOST  = 3;
	localparam int MSK_W     = 4;
	// Byte framing: bit count on the acknowledge clock
	localparam logic [3:0] ACK_BIT = 4'h8;
	// Recovery timing at a 40 MHz core clock
	localparam int CLK_NS        = 25;
	localparam int RECOV_HALF_NS = 5000;
	localparam int RECOV_PULSES  = 9;
	localparam logic [7:0] RECOV_HALF_CYC = 8'(RECOV_HALF_NS / CLK_NS);
	localparam logic [4:0] RECOV_HALVES   = 5'(2 * RECOV_PULSES);
	// Recovery sequencer and upstream slave phases
	typedef enum logic [1:0] {R_IDLE, R_CLK, R_STOP} recov_e;
	typedef enum logic [2:0] {P_IDLE, P_ADDR, P_CMD, P_WDATA, P_RDATA} phase_e;
endpackage

// ---- pkg/upstream_if.sv ----
// Register access carrier between an upstream slave and the core
interface upstream_if;
	logic       wr;
	logic       rd;
	logic       stop;
	logic [1:0] ptr;
	logic [7:0] wdata;
	logic [7:0] rdata;
	modport slave (output wr, rd, stop, ptr, wdata, input rdata);
	modport core  (input wr, rd, stop, ptr, wdata, output rdata);
endinterface

// ---- src/upstream_slave.sv ----
// Upstream serial slave: address, pointer, register write and read
module upstream_slave (
	input  wire logic       clock_i,  // Core clock
	input  wire logic       rstn_i,   // Async reset, active low
	input  wire logic [6:0] addr_i,   // Own slave address
	input  wire logic       scl_i,    // Upstream clock pin
	input  wire logic       sda_i,    // Upstream data pin
	output logic            sda_oe_o, // Pull data low
	upstream_if.slave       bus       // Register access
);
	typedef struct packed {
		logic [1:0]      scl_s;
		logic [1:0]      sda_s;
		logic            scl_p;
		logic            sda_p;
		msel_pkg::phase_e ph;
		logic [3:0]      bits;
		logic [7:0]      sh;
		logic [7:0]      tx;
		logic [1:0]      ptr;
		logic            drv;
		logic            wr;
		logic            rd;
		logic            stop;
	} slave_s;

	slave_s q;
	slave_s n;
	logic   scl;
	logic   sda;
	logic   ack_ok;

	// Synchronised pin levels, second stage only
	assign scl = q.scl_s[1];
	assign sda = q.sda_s[1];

	// Acknowledge decision at the fall after the eighth bit
	assign ack_ok = (q.ph == msel_pkg::P_ADDR && q.sh[7:1] == addr_i)
		| (q.ph == msel_pkg::P_CMD && q.sh[7:5] == 3'h0 && q.sh[3:2] == 2'h0
		&& q.sh[1:0] != msel_pkg::PTR_NONE)
		| (q.ph == msel_pkg::P_WDATA && q.ptr != msel_pkg::PTR_STAT);

	// Next state
	always_comb begin
		n = q;
		n.scl_s = {q.scl_s[0], scl_i};
		n.sda_s = {q.sda_s[0], sda_i};
		n.scl_p = scl;
		n.sda_p = sda;
		n.wr = 1'b0;
		n.rd = 1'b0;
		n.stop = 1'b0;
		if (scl && q.scl_p && q.sda_p && !sda) begin
			n.ph = msel_pkg::P_ADDR;
			n.bits = 4'h0;
			n.drv = 1'b0;
		end else if (scl && q.scl_p && !q.sda_p && sda) begin
			n.ph = msel_pkg::P_IDLE;
			n.drv = 1'b0;
			n.stop = 1'b1;
		end else if (scl && !q.scl_p && q.ph != msel_pkg::P_IDLE) begin
			if (q.bits != msel_pkg::ACK_BIT) begin
				n.sh = {q.sh[6:0], sda};
				n.bits = q.bits + 4'h1;
			end else begin
				n.bits = 4'h0;
				unique case (q.ph)
					msel_pkg::P_IDLE: begin
					end
					msel_pkg::P_ADDR: begin
						if (!q.drv) begin
							n.ph = msel_pkg::P_IDLE;
						end else if (q.sh[0]) begin
							n.ph = msel_pkg::P_RDATA;
							n.tx = bus.rdata;
							n.rd = 1'b1;
						end else begin
							n.ph = msel_pkg::P_CMD;
						end
					end
					msel_pkg::P_CMD: begin
						n.ph = q.drv ? msel_pkg::P_WDATA : msel_pkg::P_IDLE;
						if (q.drv) begin
							n.ptr = q.sh[1:0];
						end
					end
					msel_pkg::P_WDATA: begin
						n.wr = q.drv;
					end
					msel_pkg::P_RDATA: begin
						if (sda) begin
							n.ph = msel_pkg::P_IDLE;
						end else begin
							n.tx = bus.rdata;
							n.rd = 1'b1;
						end
					end
				endcase
			end
		end else if (!scl && q.scl_p && q.ph != msel_pkg::P_IDLE) begin
			if (q.bits == msel_pkg::ACK_BIT) begin
				n.drv = ack_ok;
			end else begin
				n.drv = q.ph == msel_pkg::P_RDATA && !q.tx[~q.bits[2:0]];
			end
		end
	end

	// State register
	always_ff @(posedge clock_i or negedge rstn_i) begin
		if (!rstn_i) begin
			q <= '0;
		end else begin
			q <= n;
		end
	end

	// Outputs
	assign sda_oe_o  = q.drv;
	assign bus.wr    = q.wr;
	assign bus.rd    = q.rd;
	assign bus.stop  = q.stop;
	assign bus.ptr   = q.ptr;
	assign bus.wdata = q.sh;

	default clocking @(posedge clock_i); endclocking
	default disable iff (!rstn_i);

	a_write_on_ack: assert property (q.wr |-> $past(scl) && !$past(q.scl_p) && $past(q.bits) == msel_pkg::ACK_BIT)
		else $error("register write not on acknowledge clock rise");
endmodule

// ---- src/msel_core.sv ----
// Two-to-one master selector core: registers, switching, recovery, interrupts
// Behaviour
// - No arbitration, any master takes the bus
// - Equal own and peer select means ownership
// - Downstream connected only when connect bits differ
// - Disconnect combination ignores select bits entirely
// - Disconnected former owner gets lost flag, interrupt
// - Differing connect bits connect the select owner, maybe recover
// - New select owner replaces old owner, interrupts raised
// - Ownership move flags old owner, maskable interrupt
// - Recovery sends nine downstream clock pulses
// - Downstream data stays released during recovery clocks
// - Recovery ends with a downstream STOP
// - Recovery done connects, flags, maskable interrupt
// - Switching happens on requester's own STOP
// - Switch on busy bus flags dirty, maskable
// - Test bits force own or peer interrupt
// - Register writes land on acknowledge clock rise
// - Separate mask register copy per master
// - Downstream interrupt passes unless masked
module msel_core (
	input  wire logic       clock_i,      // Core clock, 40 MHz
	input  wire logic       rstn_i,       // Async reset, active low
	input  wire logic [6:0] slave_addr_i, // Static slave address
	input  wire logic [1:0] up_scl_i,     // Upstream clock pins
	input  wire logic [1:0] up_sda_i,     // Upstream data pins
	output logic      [1:0] up_sda_oe_o,  // Upstream data pull low
	output logic      [1:0] int_n_oe_o,   // Interrupt pins pull low
	input  wire logic       ds_scl_i,     // Downstream clock pin
	input  wire logic       ds_sda_i,     // Downstream data pin
	output logic            ds_scl_oe_o,  // Downstream clock pull low
	output logic            ds_sda_oe_o,  // Downstream data pull low
	input  wire logic       ds_irq_n_i,   // Downstream interrupt, low active
	output logic            link_on_o,    // Downstream joined to a master
	output logic            link_owner_o  // Joined master index
);
	typedef struct packed {
		logic [1:0]                       dsc_s;
		logic [1:0]                       dsd_s;
		logic [1:0]                       irqn_s;
		logic                             dsc_p;
		logic                             dsd_p;
		logic [1:0][msel_pkg::MSK_W-1:0]  mask;
		logic [1:0]                       sel;
		logic [1:0]                       con;
		logic [1:0]                       rreq;
		logic [1:0]                       ttest;
		logic [1:0]                       ptest;
		logic [1:0]                       pend;
		logic [1:0]                       lost;
		logic [1:0]                       dirty;
		logic [1:0]                       rdone;
		logic                             on;
		logic                             owner;
		logic                             busy;
		logic                             tgt;
		msel_pkg::recov_e                 rs;
		logic [7:0]                       cnt;
		logic [4:0]                       halves;
		logic                             scl_drv;
		logic                             sda_drv;
		logic [1:0]                       irq;
	} core_s;

	core_s      q;
	core_s      n;
	logic [1:0] wr_w;
	logic [1:0] rd_w;
	logic [1:0] stop_w;
	logic [1:0] ptr_w [2];
	logic [7:0] wd_w  [2];
	logic [7:0] rdat  [2];
	logic [3:0] pulses_q;

	upstream_if u_if [2] ();

	// One upstream slave per master channel
	for (genvar g = 0; g < 2; g++) begin : g_up
		upstream_slave u_slave (
			.clock_i  (clock_i),
			.rstn_i   (rstn_i),
			.addr_i   (slave_addr_i),
			.scl_i    (up_scl_i[g]),
			.sda_i    (up_sda_i[g]),
			.sda_oe_o (up_sda_oe_o[g]),
			.bus      (u_if[g])
		);
		assign wr_w[g]       = u_if[g].wr;
		assign rd_w[g]       = u_if[g].rd;
		assign stop_w[g]     = u_if[g].stop;
		assign ptr_w[g]      = u_if[g].ptr;
		assign wd_w[g]       = u_if[g].wdata;
		assign u_if[g].rdata = rdat[g];
	end

	// Peer select as seen by channel c
	function automatic logic peer_sel(input logic [1:0] sel, input int c);
		return (c == 0) ? sel[1] : !sel[0];
	endfunction

	// Read-back bytes per channel
	always_comb begin
		for (int c = 0; c < 2; c++) begin
			rdat[c] = 8'h00;
			unique case (ptr_w[c])
				msel_pkg::PTR_MASK: rdat[c][msel_pkg::MSK_W-1:0] = q.mask[c];
				msel_pkg::PTR_CTRL: begin
					rdat[c][msel_pkg::CTL_SEL]   = q.sel[c];
					rdat[c][msel_pkg::CTL_PSEL]  = peer_sel(q.sel, c);
					rdat[c][msel_pkg::CTL_CON]   = q.con[c];
					rdat[c][msel_pkg::CTL_PCON]  = q.con[1-c];
					rdat[c][msel_pkg::CTL_RREQ]  = q.rreq[c];
					rdat[c][msel_pkg::CTL_TEST]  = q.ttest[c];
					rdat[c][msel_pkg::CTL_PTEST] = q.ptest[c];
				end
				msel_pkg::PTR_STAT: begin
					rdat[c][msel_pkg::MSK_LOST]  = q.lost[c];
					rdat[c][msel_pkg::MSK_DIRTY] = q.dirty[c];
					rdat[c][msel_pkg::MSK_RDONE] = q.rdone[c];
					rdat[c][msel_pkg::MSK_INTIN] = !q.irqn_s[1];
				end
				msel_pkg::PTR_NONE: rdat[c] = 8'h00;
			endcase
		end
	end

	// Next state of the core
	always_comb begin
		logic non;
		logic nown;
		non = 1'b0;
		nown = 1'b0;
		n = q;
		n.dsc_s = {q.dsc_s[0], ds_scl_i};
		n.dsd_s = {q.dsd_s[0], ds_sda_i};
		n.irqn_s = {q.irqn_s[0], ds_irq_n_i};
		n.dsc_p = q.dsc_s[1];
		n.dsd_p = q.dsd_s[1];
		// Bus sensor
		if (q.dsc_s[1] && q.dsc_p && q.dsd_p && !q.dsd_s[1]) begin
			n.busy = 1'b1;
		end else if (q.dsc_s[1] && q.dsc_p && !q.dsd_p && q.dsd_s[1]) begin
			n.busy = 1'b0;
		end
		// Register access per channel; status clear first so sets win
		for (int c = 0; c < 2; c++) begin
			if (rd_w[c] && ptr_w[c] == msel_pkg::PTR_STAT) begin
				n.lost[c] = 1'b0;
				n.dirty[c] = 1'b0;
				n.rdone[c] = 1'b0;
			end
			if (wr_w[c] && ptr_w[c] == msel_pkg::PTR_MASK) begin
				n.mask[c] = wd_w[c][msel_pkg::MSK_W-1:0];
			end
			if (wr_w[c] && ptr_w[c] == msel_pkg::PTR_CTRL) begin
				n.sel[c]   = wd_w[c][msel_pkg::CTL_SEL];
				n.con[c]   = wd_w[c][msel_pkg::CTL_CON];
				n.rreq[c]  = wd_w[c][msel_pkg::CTL_RREQ];
				n.ttest[c] = wd_w[c][msel_pkg::CTL_TEST];
				n.ptest[c] = wd_w[c][msel_pkg::CTL_PTEST];
				n.pend[c]  = 1'b1;
			end
		end
		// Apply a pending change on its writer's STOP, no arbitration
		for (int c = 0; c < 2; c++) begin
			if (stop_w[c] && q.pend[c] && q.rs == msel_pkg::R_IDLE) begin
				n.pend[c] = 1'b0;
				non = q.con[0] ^ q.con[1];
				nown = q.sel[0] != q.sel[1];
				if (!non) begin
					if (q.on) begin
						n.lost[q.owner] = 1'b1;
					end
					n.on = 1'b0;
				end else if (!(q.on && nown == q.owner)) begin
					if (q.on) begin
						n.lost[q.owner] = 1'b1;
					end
					n.tgt = nown;
					n.rreq[c] = 1'b0;
					if (q.rreq[c]) begin
						n.on = 1'b0;
						n.rs = msel_pkg::R_CLK;
						n.cnt = 8'h00;
						n.halves = 5'h00;
						n.scl_drv = 1'b1;
					end else begin
						n.on = 1'b1;
						n.owner = nown;
						if (q.busy) begin
							n.dirty[nown] = 1'b1;
						end
					end
				end
			end
		end
		// Recovery: nine clocks with data released, then a STOP
		if (q.rs != msel_pkg::R_IDLE) begin
			n.cnt = q.cnt + 8'h01;
			if (q.cnt == msel_pkg::RECOV_HALF_CYC - 8'h01) begin
				n.cnt = 8'h00;
				n.halves = q.halves + 5'h01;
				if (q.rs == msel_pkg::R_CLK) begin
					n.scl_drv = !q.scl_drv;
					if (q.halves == msel_pkg::RECOV_HALVES - 5'h01) begin
						n.rs = msel_pkg::R_STOP;
						n.halves = 5'h00;
						n.sda_drv = 1'b1;
					end
				end else if (q.halves == 5'h00) begin
					n.scl_drv = 1'b0;
				end else begin
					n.sda_drv = 1'b0;
					n.rs = msel_pkg::R_IDLE;
					n.on = 1'b1;
					n.owner = q.tgt;
					n.rdone[q.tgt] = 1'b1;
				end
			end
		end
		// Interrupt levels per channel
		for (int c = 0; c < 2; c++) begin
			n.irq[c] = (q.lost[c] && !q.mask[c][msel_pkg::MSK_LOST])
				|| (q.dirty[c] && !q.mask[c][msel_pkg::MSK_DIRTY])
				|| (q.rdone[c] && !q.mask[c][msel_pkg::MSK_RDONE])
				|| (!q.irqn_s[1] && !q.mask[c][msel_pkg::MSK_INTIN])
				|| q.ttest[c] || q.ptest[1-c];
		end
	end

	// State register
	always_ff @(posedge clock_i or negedge rstn_i) begin
		if (!rstn_i) begin
			q <= '0;
		end else begin
			q <= n;
		end
	end

	// Outputs
	assign int_n_oe_o   = q.irq;
	assign ds_scl_oe_o  = q.scl_drv;
	assign ds_sda_oe_o  = q.sda_drv;
	assign link_on_o    = q.on;
	assign link_owner_o = q.owner;

	// Released clock pulses counted during recovery
	always_ff @(posedge clock_i or negedge rstn_i) begin
		if (!rstn_i) begin
			pulses_q <= 4'h0;
		end else if (q.rs == msel_pkg::R_IDLE) begin
			pulses_q <= 4'h0;
		end else if (q.rs == msel_pkg::R_CLK && q.scl_drv && !n.scl_drv) begin
			pulses_q <= pulses_q + 4'h1;
		end
	end

	default clocking @(posedge clock_i); endclocking
	default disable iff (!rstn_i);

	a_recov_sda_free: assert property (q.rs == msel_pkg::R_CLK |-> !ds_sda_oe_o)
		else $error("data driven during recovery clocks");
	a_nine_pulses: assert property (q.rs == msel_pkg::R_CLK && n.rs == msel_pkg::R_STOP |-> pulses_q == 4'h9)
		else $error("recovery pulse count not nine");
	a_stop_edge: assert property (q.rs == msel_pkg::R_STOP && n.rs == msel_pkg::R_IDLE
		|-> !ds_scl_oe_o && ds_sda_oe_o ##1 !ds_sda_oe_o && link_on_o)
		else $error("recovery does not end in a STOP");
	a_rdone_set: assert property ($rose(link_on_o) && $past(q.rs) == msel_pkg::R_STOP |-> q.rdone[q.owner])
		else $error("recovery done flag missing");
	a_off_lost: assert property ($fell(link_on_o) |-> q.lost[q.owner])
		else $error("former owner not flagged");
	a_on_at_stop: assert property ($rose(link_on_o) && $past(q.rs) == msel_pkg::R_IDLE |-> $past(stop_w) != 2'h0)
		else $error("switch without a STOP");
	a_test_irq: assert property (q.ttest[0] || q.ptest[1] |=> int_n_oe_o[0])
		else $error("test bit did not raise interrupt");
	a_intin_pass: assert property (!q.irqn_s[1] && !q.mask[1][msel_pkg::MSK_INTIN] |=> int_n_oe_o[1])
		else $error("downstream interrupt not passed");
	a_mask_block: assert property (q.lost[0] && q.mask[0][msel_pkg::MSK_LOST] && !q.dirty[0] && !q.rdone[0]
		&& q.irqn_s[1] && !q.ttest[0] && !q.ptest[1] |=> !int_n_oe_o[0])
		else $error("masked lost flag raised interrupt");
endmodule

// ---- tb/upstream_master.sv ----
// Behavioural upstream bus master for one channel of the selector
module upstream_master #(
	parameter logic [6:0] ADDR = 7'h74
) (
	input  wire logic scl_i,    // Resolved clock line
	input  wire logic sda_i,    // Resolved data line
	output logic      scl_oe_o, // Pulls clock low
	output logic      sda_oe_o  // Pulls data low
);
	timeunit 1ns;
	timeprecision 1ps;

	// Lines released at time zero, clock stands high between frames
	initial begin
		scl_oe_o = 1'b0;
		sda_oe_o = 1'b0;
	end

	// Start condition, offset so edges never meet the core clock
	task automatic start();
		#7 sda_oe_o = 1'b1;
		#50 scl_oe_o = 1'b1;
	endtask

	// Stop condition, clock left released
	task automatic stop();
		#50 sda_oe_o = 1'b1;
		#50 scl_oe_o = 1'b0;
		#50 sda_oe_o = 1'b0;
		#50;
	endtask

	// One 200 ns bit: data set while low, line sampled mid-high
	task automatic bit_io(input logic b, output logic s);
		#50 sda_oe_o = !b;
		#50 scl_oe_o = 1'b0;
		#50 s = sda_i;
		#50 scl_oe_o = 1'b1;
	endtask

	// Byte out MSB first, then the ninth bit at level a
	task automatic xfer(input logic [7:0] tx, input logic a, output logic [7:0] rx, output logic s);
		for (int i = 7; i >= 0; i--)
			bit_io(tx[i], rx[i]);
		bit_io(a, s);
	endtask

	// Register write; the stop may be held back by the caller
	task automatic write(input logic [1:0] ptr, input logic [7:0] d, input logic fin, output logic ack);
		logic [7:0] rx;
		logic       s;
		start();
		xfer({ADDR, 1'b0}, 1'b1, rx, s);
		xfer({6'h00, ptr}, 1'b1, rx, s);
		xfer(d, 1'b1, rx, s);
		ack = !s;
		if (fin)
			stop();
	endtask

	// Register read: pointer set, then one byte ended by a not-acknowledge
	task automatic read(input logic [1:0] ptr, output logic [7:0] d);
		logic [7:0] rx;
		logic       s;
		start();
		xfer({ADDR, 1'b0}, 1'b1, rx, s);
		xfer({6'h00, ptr}, 1'b1, rx, s);
		stop();
		start();
		xfer({ADDR, 1'b1}, 1'b1, rx, s);
		xfer(8'hFF, 1'b1, d, s);
		stop();
	endtask
endmodule

// ---- tb/i2c_master_selector_control_bench.sv ----
// Self-checking bench of the master selector core
module i2c_master_selector_control_bench;
	timeunit 1ns;
	timeprecision 1ps;
	localparam logic [6:0] ADDR = 7'h74;
	logic       clock_i;
	logic       rstn_i;
	logic       ds_irq_n_i;
	logic       ds_scl_pull;
	logic       ds_sda_pull;
	logic [1:0] m_scl_oe;
	logic [1:0] m_sda_oe;
	logic [1:0] up_scl;
	logic [1:0] up_sda;
	logic [1:0] up_sda_oe_o;
	logic [1:0] int_n_oe_o;
	logic [1:0] jn;
	logic       ds_scl;
	logic       ds_sda;
	logic       ds_scl_oe_o;
	logic       ds_sda_oe_o;
	logic       link_on_o;
	logic       link_owner_o;
	logic [7:0] rd;
	logic       ak;
	logic       bad_rec;
	logic       stop_ok;
	int         pulses;
	int         miscompares;
	int         tests_run;

	// Open-drain wires, upstream joined to downstream at the owner
	assign jn = link_on_o ? (link_owner_o ? 2'h2 : 2'h1) : 2'h0;
	assign ds_scl = !(ds_scl_oe_o || ds_scl_pull || |(jn & m_scl_oe));
	assign ds_sda = !(ds_sda_oe_o || ds_sda_pull || |(jn & (m_sda_oe | up_sda_oe_o)));
	for (genvar c = 0; c < 2; c++) begin : g_up
		assign up_scl[c] = !(m_scl_oe[c] || (jn[c] && !ds_scl));
		assign up_sda[c] = !(m_sda_oe[c] || up_sda_oe_o[c] || (jn[c] && !ds_sda));
	end

	msel_core dut (
		.clock_i     (clock_i),
		.rstn_i      (rstn_i),
		.slave_addr_i(ADDR),
		.up_scl_i    (up_scl),
		.up_sda_i    (up_sda),
		.up_sda_oe_o (up_sda_oe_o),
		.int_n_oe_o  (int_n_oe_o),
		.ds_scl_i    (ds_scl),
		.ds_sda_i    (ds_sda),
		.ds_scl_oe_o (ds_scl_oe_o),
		.ds_sda_oe_o (ds_sda_oe_o),
		.ds_irq_n_i  (ds_irq_n_i),
		.link_on_o   (link_on_o),
		.link_owner_o(link_owner_o)
	);
	upstream_master #(.ADDR(ADDR)) m0 (.scl_i(up_scl[0]), .sda_i(up_sda[0]), .scl_oe_o(m_scl_oe[0]),
		.sda_oe_o(m_sda_oe[0]));
	upstream_master #(.ADDR(ADDR)) m1 (.scl_i(up_scl[1]), .sda_i(up_sda[1]), .scl_oe_o(m_scl_oe[1]),
		.sda_oe_o(m_sda_oe[1]));

	// Clock releases with data released count as recovery pulses
	always @(negedge ds_scl_oe_o) begin
		if (rstn_i === 1'b1 && ds_sda_oe_o === 1'b0)
			pulses++;
	end
	// Data may only be pulled once all nine pulses are out
	always @(posedge ds_sda_oe_o) begin
		if (rstn_i === 1'b1 && pulses != 9)
			bad_rec = 1'b1;
	end
	// Data released while clock high closes recovery with a stop
	always @(negedge ds_sda_oe_o) begin
		if (rstn_i === 1'b1)
			stop_ok = ds_scl;
	end

	initial begin
		clock_i = 1'b0;
		forever #12.5 clock_i = !clock_i;
	end

	task automatic check(input string name, input logic [7:0] seen, input logic [7:0] exp);
		tests_run++;
		if (seen !== exp) begin
			miscompares++;
			$display("unexpected %s: expected %h, seen %h", name, exp, seen);
		end
	endtask

	task automatic finish_test();
		if (miscompares == 0 && tests_run > 0) begin
			$display("All tests passed");
		end else begin
			$display("Some tests failed");
		end
		$finish;
	endtask

	task automatic cycles(input int n);
		repeat (n) @(posedge clock_i);
	endtask

	// Bounded wait for link state {on, owner}
	task automatic wait_link(input logic [1:0] st);
		int n;
		n = 0;
		while ({link_on_o, link_owner_o} !== st && n < 8000) begin
			@(posedge clock_i);
			n++;
		end
		if (n == 8000) begin
			miscompares++;
			finish_test();
		end
	endtask

	// Hard limit on the whole run
	initial begin
		#1ms;
		miscompares++;
		finish_test();
	end

	initial begin
		rstn_i = 1'b0;
		ds_irq_n_i = 1'b1;
		ds_scl_pull = 1'b0;
		ds_sda_pull = 1'b0;
		bad_rec = 1'b0;
		stop_ok = 1'b0;
		pulses = 0;
		miscompares = 0;
		tests_run = 0;
		cycles(5);
		rstn_i <= 1'b1;
		cycles(5);
		// Reset state, then private mask copies
		check("link", {link_on_o, int_n_oe_o}, 8'h00);
		m0.write(msel_pkg::PTR_MASK, 8'hFF, 1'b1, ak);
		m0.read(msel_pkg::PTR_MASK, rd);
		check("mask0", rd, 8'h0F);
		m1.read(msel_pkg::PTR_MASK, rd);
		check("mask1", rd, 8'h00);
		m0.write(msel_pkg::PTR_MASK, 8'h02, 1'b1, ak);
		// Master 0 connects; nothing moves before its stop
		m0.write(msel_pkg::PTR_CTRL, 8'h04, 1'b0, ak);
		check("ctrl ack", ak, 8'h01);
		cycles(20);
		check("before stop", link_on_o, 8'h00);
		m0.stop();
		wait_link(2'h2);
		m0.read(msel_pkg::PTR_CTRL, rd);
		check("ctrl0", rd, 8'h04);
		m1.read(msel_pkg::PTR_CTRL, rd);
		check("ctrl1", rd, 8'h0A);
		// Master 1 takes over while the downstream bus is left busy
		m1.write(msel_pkg::PTR_CTRL, 8'h01, 1'b0, ak);
		ds_sda_pull <= 1'b1;
		cycles(8);
		ds_scl_pull <= 1'b1;
		cycles(8);
		ds_sda_pull <= 1'b0;
		cycles(8);
		ds_scl_pull <= 1'b0;
		cycles(8);
		check("owner held", {link_on_o, link_owner_o}, 8'h02);
		m1.stop();
		wait_link(2'h3);
		cycles(4);
		check("irq swap", int_n_oe_o, 8'h03);
		m1.read(msel_pkg::PTR_STAT, rd);
		check("stat1 dirty", rd, 8'h04);
		m0.read(msel_pkg::PTR_STAT, rd);
		check("stat0 lost", rd, 8'h08);
		cycles(4);
		check("irq cleared", int_n_oe_o, 8'h00);
		// Master 0 takes back with recovery, both interrupts masked
		m1.write(msel_pkg::PTR_MASK, 8'h08, 1'b1, ak);
		m0.write(msel_pkg::PTR_CTRL, 8'h15, 1'b1, ak);
		wait_link(2'h1);
		wait_link(2'h2);
		check("pulses", 8'(pulses), 8'h09);
		check("data held", bad_rec, 8'h00);
		check("rec stop", stop_ok, 8'h01);
		cycles(4);
		check("irq masked", int_n_oe_o, 8'h00);
		m0.read(msel_pkg::PTR_STAT, rd);
		check("stat0 rdone", rd, 8'h02);
		m1.read(msel_pkg::PTR_STAT, rd);
		check("stat1 lost", rd, 8'h08);
		// Owner switches both off, select change ignored
		m0.write(msel_pkg::PTR_CTRL, 8'h00, 1'b1, ak);
		wait_link(2'h0);
		cycles(4);
		check("irq off", int_n_oe_o, 8'h01);
		m0.read(msel_pkg::PTR_STAT, rd);
		check("stat0 off", rd, 8'h08);
		// Test bits drive own and peer interrupt
		m1.write(msel_pkg::PTR_CTRL, 8'h40, 1'b1, ak);
		cycles(6);
		check("test own", int_n_oe_o, 8'h02);
		m1.write(msel_pkg::PTR_CTRL, 8'h80, 1'b1, ak);
		cycles(6);
		check("test peer", int_n_oe_o, 8'h01);
		m1.write(msel_pkg::PTR_CTRL, 8'h00, 1'b1, ak);
		// Downstream interrupt passes only where unmasked
		m1.write(msel_pkg::PTR_MASK, 8'h01, 1'b1, ak);
		ds_irq_n_i <= 1'b0;
		cycles(6);
		check("irq in", int_n_oe_o, 8'h01);
		ds_irq_n_i <= 1'b1;
		// Status pointer is read-only: data refused
		m0.write(msel_pkg::PTR_STAT, 8'h00, 1'b1, ak);
		check("stat nack", ak, 8'h00);
		finish_test();
	end
endmodule
